// *** shared/sdcc_pkg.sv ***
// constants and carrier types for the card clock, detect and configuration bank
package sdcc_pkg;
	localparam int unsigned AW = 8;
	localparam logic [7:0] OFS_MASK     = 8'h2c;
	localparam logic [7:0] OFS_CLK      = 8'h30;
	localparam logic [7:0] OFS_PIN      = 8'h3c;
	localparam logic [7:0] OFS_DBG1     = 8'h40;
	localparam logic [7:0] OFS_DBG2     = 8'h44;
	localparam logic [7:0] OFS_IOMODE   = 8'h48;
	localparam logic [7:0] OFS_EVSTAT   = 8'h50;
	localparam logic [7:0] OFS_EVCLR    = 8'h54;
	localparam logic [7:0] OFS_EVEN     = 8'h58;
	// mask register layout and reset
	localparam logic [31:0] MASK_WMASK  = 32'h0000_006e;
	localparam logic [31:0] MASK_RESET  = 32'h0000_006e;
	// clock control fields
	localparam int unsigned DIV_LSB     = 8;
	localparam int unsigned DIV_W       = 13;
	localparam logic [12:0] DIV_RESET   = 13'h0080;
	localparam int unsigned TUNE_LSB    = 2;
	localparam int unsigned GUARD_BIT   = 1;
	localparam int unsigned HALT_BIT    = 0;
	localparam logic [31:0] CLK_WMASK   = 32'h001f_ff0f;
	localparam logic [31:0] CLK_RESET   = 32'h0000_8001;
	// pin and detect fields
	localparam int unsigned OTIM_LSB    = 19;
	localparam int unsigned ITIM_LSB    = 6;
	localparam int unsigned TIM_W       = 13;
	localparam int unsigned OD_BIT      = 5;
	localparam int unsigned POL_BIT     = 4;
	localparam int unsigned DETEN_BIT   = 3;
	localparam int unsigned OSEL_BIT    = 2;
	localparam int unsigned ISEL_BIT    = 1;
	localparam int unsigned SRC_BIT     = 0;
	localparam logic [31:0] PIN_RESET   = 32'h0000_0019;
	// debug and mode fields
	localparam logic [31:0] DBG2_WMASK  = 32'hc000_0000;
	localparam logic [31:0] IOMODE_WMASK = 32'h0000_000e;
	localparam logic [14:0] DSTATE_RESET = 15'h0001;
	localparam logic [15:0] CSTATE_RESET = 16'h0001;
	localparam int unsigned DSTATE_LSB  = 16;
	localparam int unsigned VCNT_LSB    = 16;
	localparam int unsigned NEV         = 3;
	localparam logic [NEV-1:0] EV_ZERO  = 3'h0;
	// event bits: insert, remove, guard pause
	localparam int unsigned EV_INS      = 0;
	localparam int unsigned EV_REM      = 1;
	localparam int unsigned EV_PAUSE    = 2;
	localparam logic [31:0] ZERO32      = 32'h0000_0000;

	typedef struct packed {
		logic [AW-1:0] adr;
		logic [31:0]   dat;
		logic [3:0]    sel;
		logic          we;
		logic          cyc;
		logic          stb;
	} sdcc_wbreq_s;

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [1:0]       tune;
		logic             guard;
		logic             halt;
	} sdcc_clkcfg_s;
endpackage

// *** hdl/sdcc_top.sv ***
// card clock, pin timing, presence detect and configuration register bank
// Behaviour
// - data check error and data done mask bits 6 and 5, reset one
// - command timeout, crc, done mask bits 3,2,1 reset one; 4,0 reserved
// - card clock is bus clock over ratio field plus one; field resets 0x80
// - two-bit receive sample delay select, zero means no delay
// - guard bit pauses card clock and module enable near fifo overrun/underrun
// - halt bit stops card clock; resets to one
// - 13-bit output timing applied only when output select set
// - 13-bit input timing used only when input select set
// - open-drain bit makes command line open-drain, else push-pull
// - polarity bit: one means high detect level shows a card present
// - presence detection only while detect enable is set
// - source bit one senses presence on data line 3; zero unsupported
// - read-only data and command engine state debug views
// - debug select writable, valid-data and host-word counters read-only
// - interrupt mode bit 3 enables four-line irq on multi-block transfers
// - interrupt mode bit 2 enables four-line irq on single-block transfers
// - interrupt mode bit 1 enables sdio card interrupt detection
`timescale 1ns/1ps
module sdcc_top
	import sdcc_pkg::*;
(
	// system
	input  wire logic        CORE_CLK,
	input  wire logic        SRST,
	// classic wishbone slave
	input  wire logic [AW-1:0] WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_WE_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// engine side status
	input  wire logic        FIFO_NEAR_LIMIT,
	input  wire logic        FIFO_HOST_ACCESS,
	input  wire logic [14:0] DATA_ENGINE_STATE,
	input  wire logic [15:0] COMMAND_ENGINE_STATE,
	input  wire logic [9:0]  VALID_DATA_COUNT,
	input  wire logic [13:0] HOST_WORD_COUNT,
	// card pins
	input  wire logic        LINE3_IN,
	output logic             CARD_CLK,
	output logic             CMD_OUT_EN_N_OD,
	output logic             CARD_PRESENT,
	// configuration towards the engines
	output logic             MODULE_CLK_EN,
	output logic [4:0]       MASK_LOW,
	output logic [1:0]       RX_SAMPLE_DELAY,
	output logic [TIM_W-1:0] OUT_TIMING,
	output logic [TIM_W-1:0] IN_TIMING,
	output logic             COMMAND_LINE_OPEN_DRAIN,
	output logic [1:0]       DEBUG_SELECT,
	output logic             FOUR_LINE_IRQ_MULTIBLOCK,
	output logic             FOUR_LINE_IRQ_SINGLEBLOCK,
	output logic             SDIO_IRQ_ENABLE,
	// interrupt
	output logic             IRQ
);
	logic [31:0]  mask_reg;
	logic [31:0]  clk_reg;
	logic [31:0]  pin_reg;
	logic [31:0]  dbg2_reg;
	logic [31:0]  iomode_reg;
	logic [NEV-1:0] ev_stat;
	logic [NEV-1:0] ev_en;
	logic [DIV_W-1:0] div_cnt;
	logic         clk_q;
	logic         paused;
	logic [2:0]   l3_sync;
	logic         present_q;
	sdcc_wbreq_s  req;
	sdcc_clkcfg_s cfg;

	// request bundle and decode
	assign req = '{adr: WB_ADR_I, dat: WB_DAT_I, sel: WB_SEL_I, we: WB_WE_I, cyc: WB_CYC_I, stb: WB_STB_I};
	wire          access   = req.cyc && req.stb && !WB_ACK_O;
	wire          wr       = access && req.we;
	wire [31:0]   be_mask  = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
	wire          hit_mask = req.adr == OFS_MASK;
	wire          hit_clk  = req.adr == OFS_CLK;
	wire          hit_pin  = req.adr == OFS_PIN;
	wire          hit_dbg2 = req.adr == OFS_DBG2;
	wire          hit_io   = req.adr == OFS_IOMODE;
	wire          hit_clr  = req.adr == OFS_EVCLR;
	wire          hit_en   = req.adr == OFS_EVEN;

	// write merge keeps unwritable and unselected bits
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wm);
		merge = (old & ~(wm & be_mask)) | (req.dat & wm & be_mask);
	endfunction

	// configuration field views
	assign cfg = '{div: clk_reg[DIV_LSB +: DIV_W], tune: clk_reg[TUNE_LSB +: 2],
		guard: clk_reg[GUARD_BIT], halt: clk_reg[HALT_BIT]};
	assign MASK_LOW        = mask_reg[6:2] & 5'h1b;
	assign RX_SAMPLE_DELAY = cfg.tune;
	// timing values only leave the bank once their select bit is set
	assign OUT_TIMING = pin_reg[OSEL_BIT] ? pin_reg[OTIM_LSB +: TIM_W] : '0;
	assign IN_TIMING  = pin_reg[ISEL_BIT] ? pin_reg[ITIM_LSB +: TIM_W] : '0;
	assign COMMAND_LINE_OPEN_DRAIN = pin_reg[OD_BIT];
	// output enable copies the open-drain bit; it does not depend on the driven data
	assign CMD_OUT_EN_N_OD = pin_reg[OD_BIT];
	assign DEBUG_SELECT    = dbg2_reg[31:30];
	assign FOUR_LINE_IRQ_MULTIBLOCK  = iomode_reg[3];
	assign FOUR_LINE_IRQ_SINGLEBLOCK = iomode_reg[2];
	assign SDIO_IRQ_ENABLE           = iomode_reg[1];
	assign CARD_CLK        = clk_q;
	assign CARD_PRESENT    = present_q;
	assign MODULE_CLK_EN   = !paused;
	assign IRQ             = |(ev_stat & ev_en);

	// clock runs only when not halted, not paused and ratio is legal
	wire clk_run  = !cfg.halt && !paused && (cfg.div != '0);
	wire div_wrap = div_cnt >= cfg.div;
	// pause entry on near-limit, exit once the host touches the fifo
	wire next_paused = cfg.guard && (paused ? !FIFO_HOST_ACCESS : FIFO_NEAR_LIMIT);

	// presence detect: level after three-stage filter, polarity applied
	wire l3_stable = l3_sync[2] == l3_sync[1];
	wire det_level = l3_sync[1] ~^ pin_reg[POL_BIT];
	wire det_on    = pin_reg[DETEN_BIT] && pin_reg[SRC_BIT];
	wire ev_ins    = det_on && l3_stable && det_level && !present_q;
	wire ev_rem    = det_on && l3_stable && !det_level && present_q;
	wire [NEV-1:0] ev_set = {next_paused && !paused, ev_rem, ev_ins};
	wire [NEV-1:0] ev_clr = (wr && hit_clr) ? req.dat[NEV-1:0] : EV_ZERO;

	// read mux
	wire [31:0] rd_data =
		hit_mask ? (mask_reg & MASK_WMASK) :
		hit_clk  ? clk_reg :
		hit_pin  ? pin_reg :
		(req.adr == OFS_DBG1) ? {1'b0, DATA_ENGINE_STATE, COMMAND_ENGINE_STATE} :
		hit_dbg2 ? {dbg2_reg[31:30], 4'h0, VALID_DATA_COUNT, 2'h0, HOST_WORD_COUNT} :
		hit_io   ? iomode_reg :
		(req.adr == OFS_EVSTAT) ? {29'h0, ev_stat} :
		hit_en   ? {29'h0, ev_en} : ZERO32;

	// bus answer one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= ZERO32;
		end else begin
			WB_ACK_O <= access;
			WB_DAT_O <= rd_data;
		end
	end

	// register writes
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			mask_reg   <= MASK_RESET;
			clk_reg    <= CLK_RESET;
			pin_reg    <= PIN_RESET;
			dbg2_reg   <= ZERO32;
			iomode_reg <= ZERO32;
			ev_en      <= EV_ZERO;
		end else if (wr) begin
			if (hit_mask) mask_reg <= merge(mask_reg, MASK_WMASK);
			if (hit_clk) clk_reg <= merge(clk_reg, CLK_WMASK);
			if (hit_pin) pin_reg <= merge(pin_reg, 32'hffff_ffff);
			if (hit_dbg2) dbg2_reg <= merge(dbg2_reg, DBG2_WMASK);
			if (hit_io) iomode_reg <= merge(iomode_reg, IOMODE_WMASK);
			if (hit_en) ev_en <= req.dat[NEV-1:0];
		end
	end

	// card clock divider: period is ratio plus one bus cycles
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			div_cnt <= '0;
			clk_q   <= 1'b0;
			paused  <= 1'b0;
		end else begin
			paused <= next_paused;
			if (!clk_run) begin
				div_cnt <= '0;
				clk_q   <= 1'b0;
			end else begin
				div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
				// one extra bit so the largest ratio does not wrap to a zero high phase
				clk_q   <= {1'b0, div_cnt} < (({1'b0, cfg.div} + {{DIV_W{1'b0}}, 1'b1}) >> 1);
			end
		end
	end

	// detect input filter and sticky events; a set beats a same-cycle clear
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			l3_sync   <= 3'h0;
			present_q <= 1'b0;
			ev_stat   <= EV_ZERO;
		end else begin
			l3_sync <= {l3_sync[1:0], LINE3_IN};
			if (ev_ins) present_q <= 1'b1;
			else if (ev_rem || !det_on) present_q <= 1'b0;
			ev_stat <= (ev_stat & ~ev_clr) | ev_set;
		end
	end

	// checks
	a_halt_stops_clk: assert property (@(posedge CORE_CLK) disable iff (SRST)
		cfg.halt |=> !CARD_CLK) else $error("card clock ran while halted");
	a_zero_div_stop: assert property (@(posedge CORE_CLK) disable iff (SRST)
		cfg.div == '0 |=> !CARD_CLK) else $error("card clock ran with zero ratio");
	a_pause_gates_en: assert property (@(posedge CORE_CLK) disable iff (SRST)
		cfg.guard && FIFO_NEAR_LIMIT && !paused |=> !MODULE_CLK_EN) else $error("guard did not pause");
	a_no_detect_off: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!pin_reg[DETEN_BIT] |=> !CARD_PRESENT) else $error("presence seen while detect off");
	a_otiming_gate: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!pin_reg[OSEL_BIT] |-> OUT_TIMING == '0) else $error("output timing leaked");
	a_itiming_gate: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!pin_reg[ISEL_BIT] |-> IN_TIMING == '0) else $error("input timing leaked");
	a_ack_one_cycle: assert property (@(posedge CORE_CLK) disable iff (SRST)
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack timing wrong");
	a_dbg1_view: assert property (@(posedge CORE_CLK) disable iff (SRST)
		access && !req.we && req.adr == OFS_DBG1 |=> WB_DAT_O[15:0] == $past(COMMAND_ENGINE_STATE))
		else $error("debug view wrong");
	a_iomode_bits: assert property (@(posedge CORE_CLK) disable iff (SRST)
		wr && hit_io && req.sel[0] |=> SDIO_IRQ_ENABLE == $past(req.dat[1])
		&& FOUR_LINE_IRQ_SINGLEBLOCK == $past(req.dat[2])) else $error("mode bits not stored");
	a_clk_period: assert property (@(posedge CORE_CLK) disable iff (SRST)
		$rose(CARD_CLK) && cfg.div == 13'h1 && clk_run |=> !CARD_CLK) else $error("div one period wrong");
	c_clock_runs: cover property (@(posedge CORE_CLK) disable iff (SRST) $rose(CARD_CLK));
	c_insert: cover property (@(posedge CORE_CLK) disable iff (SRST) ev_ins);
	c_pause: cover property (@(posedge CORE_CLK) disable iff (SRST) $fell(MODULE_CLK_EN));
	c_irq: cover property (@(posedge CORE_CLK) disable iff (SRST) $rose(IRQ));
endmodule

// *** tb/sdcc_card.sv ***
// behavioural card: presence on data line 3, card clock period monitor
`timescale 1ns/1ps
module sdcc_card (
	// clocks
	input  wire logic CORE_CLK,
	input  wire logic CARD_CLK,
	// card state from the bench
	input  wire logic present,
	// pins and measurements
	output logic      line3,
	output int        period,
	output int        rises
);
	int   cnt = 1;
	logic last = 1'b0;
	// card pulls data line 3 to its presence level
	assign line3 = present;
	// edges between rising card clock edges, counted in bus cycles
	always @(posedge CORE_CLK) begin
		last <= CARD_CLK;
		cnt  <= cnt + 1;
		if (CARD_CLK && !last) begin
			period <= cnt;
			cnt    <= 1;
			rises  <= rises + 1;
		end
	end
	initial begin
		period = 0;
		rises  = 0;
	end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the card clock, detect and configuration bank
`timescale 1ns/1ps
module tb;
	import sdcc_pkg::*;
	typedef struct packed {
		logic [7:0]  adr;
		logic [31:0] wd;
		logic [31:0] rst;
		logic [31:0] aft;
	} sdcc_row_s;
	logic        CORE_CLK = 1'b0;
	logic        SRST = 1'b1;
	sdcc_wbreq_s wbq = '0;
	logic        near = 1'b0;
	logic        hacc = 1'b0;
	logic        present = 1'b0;
	logic [31:0] rd, dat_o;
	logic        ack, card_clk, line3, od_n, cpres, mclk, irq, od, fml, fsb, sirq;
	logic [4:0]  mask_low;
	logic [1:0]  rxd, dsel;
	logic [12:0] otim, itim;
	int          period, rises, r0, errors = 0, check_count = 0, cyc_n = 0;
	// reset value, written value and read-back per register
	sdcc_row_s rows [8] = '{
		'{OFS_MASK, ZERO32, 32'h0000_006e, ZERO32},
		'{OFS_CLK, 32'hffff_ffff, 32'h0000_8001, 32'h001f_ff0f},
		'{OFS_PIN, 32'hffff_ffff, 32'h0000_0019, 32'hffff_ffff},
		'{OFS_DBG1, 32'hffff_ffff, 32'h1234_5678, 32'h1234_5678},
		'{OFS_DBG2, 32'hffff_ffff, 32'h0155_0abc, 32'hc155_0abc},
		'{OFS_IOMODE, 32'hffff_ffff, ZERO32, 32'h0000_000e},
		'{OFS_EVEN, 32'h0000_0007, ZERO32, 32'h0000_0007},
		'{8'h7c, 32'hffff_ffff, ZERO32, ZERO32}};

	sdcc_top u_dut (.CORE_CLK(CORE_CLK), .SRST(SRST), .WB_ADR_I(wbq.adr), .WB_DAT_I(wbq.dat),
		.WB_SEL_I(wbq.sel), .WB_WE_I(wbq.we), .WB_CYC_I(wbq.cyc), .WB_STB_I(wbq.stb),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .FIFO_NEAR_LIMIT(near), .FIFO_HOST_ACCESS(hacc),
		.DATA_ENGINE_STATE(15'h1234), .COMMAND_ENGINE_STATE(16'h5678), .VALID_DATA_COUNT(10'h155),
		.HOST_WORD_COUNT(14'h0abc), .LINE3_IN(line3), .CARD_CLK(card_clk), .CMD_OUT_EN_N_OD(od_n),
		.CARD_PRESENT(cpres), .MODULE_CLK_EN(mclk), .MASK_LOW(mask_low), .RX_SAMPLE_DELAY(rxd),
		.OUT_TIMING(otim), .IN_TIMING(itim), .COMMAND_LINE_OPEN_DRAIN(od), .DEBUG_SELECT(dsel),
		.FOUR_LINE_IRQ_MULTIBLOCK(fml), .FOUR_LINE_IRQ_SINGLEBLOCK(fsb), .SDIO_IRQ_ENABLE(sirq),
		.IRQ(irq));
	sdcc_card u_card (.CORE_CLK(CORE_CLK), .CARD_CLK(card_clk), .present(present), .line3(line3),
		.period(period), .rises(rises));

	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	task automatic end_sim();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// a hang ends the run as a mismatch
	always @(posedge CORE_CLK) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			errors++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		wbq <= '{adr: a, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
		@(posedge CORE_CLK);
		// ack sampled high ends this wait; without ack only the bench timeout ends it
		while (ack !== 1'b1) begin
			@(posedge CORE_CLK);
		end
		rd = dat_o;
		wbq <= '0;
	endtask

	initial begin
		idle(10);
		SRST <= 1'b0;
		idle(1);
		chk("mask_low", 32'(mask_low), 32'h1b);
		chk("rises", 32'(rises), ZERO32);
		foreach (rows[i]) begin
			wb(1'b0, rows[i].adr, ZERO32);
			chk("reset", rd, rows[i].rst);
			wb(1'b1, rows[i].adr, rows[i].wd);
			wb(1'b0, rows[i].adr, ZERO32);
			chk("readback", rd, rows[i].aft);
		end
		chk("otim", 32'(otim), 32'h1fff);
		chk("itim", 32'(itim), 32'h1fff);
		chk("od", 32'({od, od_n}), 32'h3);
		chk("dsel", 32'(dsel), 32'h3);
		chk("iomode", 32'({fml, fsb, sirq}), 32'h7);
		chk("mask_low", 32'(mask_low), ZERO32);
		wb(1'b1, OFS_PIN, 32'hffff_fff9);
		chk("otim", 32'(otim), ZERO32);
		chk("itim", 32'(itim), ZERO32);
		// ratio and sample delay sweep
		for (int c = 0; c < 4; c++) begin
			wb(1'b1, OFS_CLK, 32'(((c + 1) << DIV_LSB) | (c << TUNE_LSB)));
			idle(20);
			chk("period", 32'(period), 32'(c + 2));
			chk("delay", 32'(rxd), 32'(c));
		end
		wb(1'b1, OFS_CLK, 32'h0000_0101);
		idle(4);
		r0 = rises;
		idle(20);
		chk("halt", 32'(rises), 32'(r0));
		wb(1'b1, OFS_CLK, ZERO32);
		idle(4);
		r0 = rises;
		idle(20);
		chk("div0", 32'(rises), 32'(r0));
		// guard pause until the host touches the fifo
		wb(1'b1, OFS_CLK, 32'h0000_0102);
		idle(4);
		near <= 1'b1;
		idle(4);
		r0 = rises;
		idle(10);
		chk("pause", 32'(rises), 32'(r0));
		chk("mclk", 32'(mclk), ZERO32);
		hacc <= 1'b1;
		near <= 1'b0;
		idle(10);
		chk("mclk", 32'(mclk), 32'h1);
		chk("resume", 32'(rises > r0), 32'h1);
		hacc <= 1'b0;
		// presence events, enable and clear
		wb(1'b1, OFS_EVCLR, 32'h7);
		idle(2);
		chk("irq", 32'(irq), ZERO32);
		present <= 1'b1;
		idle(10);
		chk("present", 32'(cpres), 32'h1);
		chk("irq", 32'(irq), 32'h1);
		wb(1'b0, OFS_EVSTAT, ZERO32);
		chk("insert", rd, 32'h1);
		wb(1'b1, OFS_EVCLR, 32'h1);
		idle(2);
		chk("irq", 32'(irq), ZERO32);
		wb(1'b1, OFS_EVEN, ZERO32);
		present <= 1'b0;
		idle(10);
		wb(1'b0, OFS_EVSTAT, ZERO32);
		chk("remove", rd, 32'h2);
		chk("irq", 32'(irq), ZERO32);
		wb(1'b1, OFS_EVEN, 32'h7);
		idle(2);
		chk("irq", 32'(irq), 32'h1);
		wb(1'b1, OFS_EVCLR, 32'h7);
		wb(1'b1, OFS_PIN, 32'hffff_fff1);
		present <= 1'b1;
		idle(10);
		wb(1'b0, OFS_EVSTAT, ZERO32);
		chk("disabled", rd, ZERO32);
		wb(1'b1, OFS_PIN, 32'hffff_ffe9);
		idle(10);
		chk("polarity", 32'(cpres), ZERO32);
		// mid-run reset returns the bank to its defaults
		SRST <= 1'b1;
		idle(2);
		SRST <= 1'b0;
		idle(1);
		chk("rst_irq", 32'(irq), ZERO32);
		chk("rst_mclk", 32'(mclk), 32'h1);
		chk("rst_clk", 32'(card_clk), ZERO32);
		wb(1'b0, OFS_CLK, ZERO32);
		chk("rst_clkreg", rd, 32'h0000_8001);
		end_sim();
	end
endmodule
